/* File: adc_consts.svh */
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// Register byte offsets on the AHB-Lite port
`define ADC_OFF_PIN_EN 8'h00
`define ADC_OFF_CTRL 8'h04
`define ADC_OFF_TRIM 8'h08
`define ADC_OFF_RES_UP 8'h0c
`define ADC_OFF_RES_HN 8'h10
`define ADC_OFF_RES_LO 8'h14
`define ADC_OFF_IRQ_ST 8'h18
`define ADC_OFF_WAKE 8'h1c
`define ADC_OFF_PIN_MUX 8'h20

// converter_control field positions
`define ADC_CTL_REFSEL 7
`define ADC_CTL_DIV_HI 6
`define ADC_CTL_DIV_LO 5
`define ADC_CTL_ACTIVE 4
`define ADC_CTL_POWER 3
`define ADC_CTL_CH_HI 2
`define ADC_CTL_CH_LO 0

// offset_trim field positions
`define ADC_TRIM_EN 7
`define ADC_TRIM_POS 6
`define ADC_TRIM_MAG_HI 5
`define ADC_TRIM_MAG_LO 3

// Flag, wake and pin mux bit positions
`define ADC_DONE_BIT 3
`define ADC_WAKE_BIT 3
`define ADC_MUX_COMP 0
`define ADC_MUX_PWM3 1

// Reset values
`define ADC_RST_BYTE 8'h00
`define ADC_RST_RES 12'h000

// Divider codes and last prescaler count per code
`define ADC_DIV_16 2'h0
`define ADC_DIV_4 2'h1
`define ADC_DIV_64 2'h2
`define ADC_DIV_8 2'h3
`define ADC_LAST_16 6'h0f
`define ADC_LAST_4 6'h03
`define ADC_LAST_64 6'h3f
`define ADC_LAST_8 6'h07

// Divided clock periods per conversion, less one
`define ADC_CONV_LAST 4'hd

// Largest 12-bit result
`define ADC_RES_MAX 13'h0fff

`endif

/* File: adc_pkg.sv */
package adc_pkg;
  // Function driven onto the shared channel-0 pin
  typedef enum logic [1:0] {ADC_PIN_PORT, ADC_PIN_ANALOG, ADC_PIN_COMP}
    adc_ch0_fn_t;
  // Function driven onto the shared reference pin
  typedef enum logic [1:0] {ADC_REF_PORT, ADC_REF_PWM, ADC_REF_VREF}
    adc_ref_fn_t;
  // Conversion sequencer states
  typedef enum logic {ADC_ST_IDLE, ADC_ST_RUN} adc_state_t;
endpackage

/* File: adc_conv_if.sv */
interface adc_conv_if;
  logic run;
  logic powered;
  logic [1:0] div_sel;
  logic done;
  // Register side drives the request, sequencer answers
  modport ctrl (output run, output powered, output div_sel, input done);
  modport engine (input run, input powered, input div_sel, output done);
endinterface

/* File: adc_conv_seq.sv */
`include "adc_consts.svh"

module adc_conv_seq
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Control side
  adc_conv_if.engine conv
);

  // Last prescaler count for each divider code
  function automatic logic [5:0] div_last(input logic [1:0] sel);
    case (sel)
      `ADC_DIV_16: div_last = `ADC_LAST_16;
      `ADC_DIV_4: div_last = `ADC_LAST_4;
      `ADC_DIV_64: div_last = `ADC_LAST_64;
      default: div_last = `ADC_LAST_8;
    endcase
  endfunction

  adc_state_t state_reg;
  logic [5:0] pre_reg;
  logic [3:0] tick_cnt_reg;
  logic done_reg;

  // Divided converter clock enable, frozen while unpowered
  wire div_tick = conv.powered && (pre_reg == div_last(conv.div_sel)); // R5
  wire conv_end = div_tick && (tick_cnt_reg == `ADC_CONV_LAST); // R20
  // Active bit still reads high in the done cycle: no restart then
  wire start = conv.run && conv.powered && !done_reg; // R21

  assign conv.done = done_reg;

  // Sequencer: fixed tick count from start to done
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ADC_ST_IDLE;
      pre_reg <= 6'h00;
      tick_cnt_reg <= 4'h0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (state_reg)
        ADC_ST_IDLE:
        begin
          pre_reg <= 6'h00;
          tick_cnt_reg <= 4'h0;
          if (start)
            state_reg <= ADC_ST_RUN;
        end
        ADC_ST_RUN:
        begin
          if (conv_end)
          begin
            done_reg <= 1'b1;
            state_reg <= ADC_ST_IDLE;
          end
          else if (div_tick)
          begin
            pre_reg <= 6'h00;
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
          end
          else if (conv.powered) // R21
            pre_reg <= pre_reg + 6'h01;
        end
        default: state_reg <= ADC_ST_IDLE;
      endcase
    end
  end

  // Done is a single-cycle pulse
  done_pulse_a: assert property ( // R20
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    conv.done |=> !conv.done)
    else $error("done pulse longer than one cycle");

  // Unpowered sequencer never advances its prescaler
  pre_hold_a: assert property ( // R21
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_reg == ADC_ST_RUN && !conv.powered) |=> $stable(pre_reg))
    else $error("prescaler moved while unpowered");

  // No second conversion from the stale active bit
  idle_after_done_a: assert property ( // R7
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    conv.done |=> (state_reg == ADC_ST_IDLE))
    else $error("sequencer restarted after completion");

endmodule // adc_conv_seq

/* File: adc_ctrl_top.sv */
// Operation
// R1: Each pin enable bit connects its port pin to the converter when 1.
// R2: Channel-0 pin: comparator output beats analog input beats port I/O.
// R3: Reference select 0 uses supply; 1 takes reference from the pin.
// R4: Reference pin: reference beats third PWM beats port; software avoids both.
// R5: Divider code 00 /16, 01 /4, 10 /64, 11 /8; reset is 00.
// R6: Software keeps oscillator within the limit for the chosen divider.
// R7: Writing 1 starts conversion; only completion clears the active bit.
// R8: Power bit 0 switches off the reference ladder; 1 operates.
// R9: Channel select code n routes analog input n to the converter.
// R10: Channel select changes only while done flag and active bit are low.
// R11: Offset correction applied only while the calibration enable bit is 1.
// R12: Offset polarity bit: 0 negative correction, 1 positive correction.
// R13: Offset magnitude code gives twice its value in LSBs, 0 to 14.
// R14: Low three bits of the offset trim register always read zero.
// R15: Completion loads bits 11..4 in upper byte, clears active, sets done.
// R16: Completion loads bits 11..8 in high nibble; its upper bits read zero.
// R17: Completion loads bits 7..0 into the low result byte.
// R18: Done flag sits at status bit 3; hardware sets, software clears.
// R19: Software sets wake enable when completion must interrupt or wake.
// R20: A conversion lasts a fixed count of divided converter clocks.
// R21: A start while unpowered produces no result and no done flag; the active bit stays set and the conversion runs once power is 1.
`include "adc_consts.svh"

module adc_ctrl_top
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  // Analog front end
  input wire logic [11:0] sample_i,
  output logic [2:0] channel_sel_o,
  output logic [7:0] analog_connect_o,
  output logic ref_from_pin_o,
  output logic ref_ladder_on_o,
  // Shared pin functions and wake
  output adc_ch0_fn_t ch0_pin_fn_o,
  output adc_ref_fn_t ref_pin_fn_o,
  output logic conversion_wake_o
);

  // Bus side state
  logic [7:0] addr_reg;
  logic addr_ok_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic hreadyout_reg;
  logic [7:0] hrdata_reg;

  // Software visible state
  logic [7:0] pin_en_reg;
  logic ref_sel_reg;
  logic [1:0] div_reg;
  logic active_reg;
  logic power_reg;
  logic [2:0] chan_reg;
  logic trim_en_reg;
  logic trim_pos_reg;
  logic [2:0] trim_mag_reg;
  logic [11:0] res_reg;
  logic done_flag_reg;
  logic wake_en_reg;
  logic comp_en_reg;
  logic pwm3_en_reg;

  // Sample synchroniser and registered pin outputs
  logic [11:0] samp_meta_reg;
  logic [11:0] samp_sync_reg;
  logic [7:0] connect_reg;
  logic [7:0] connect_next;
  adc_ch0_fn_t ch0_fn_reg;
  adc_ref_fn_t ref_fn_reg;
  logic wake_reg;

  // Decode of one register offset in the held address phase
  function automatic logic reg_sel(input logic ok, input logic [7:0] a,
                                   input logic [7:0] off);
    reg_sel = ok && (a == off);
  endfunction

  adc_conv_if conv_bus ();

  // Conversion sequencer
  adc_conv_seq u_seq (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .conv (conv_bus.engine)
  );

  // Request to the sequencer
  assign conv_bus.run = active_reg; // R7
  assign conv_bus.powered = power_reg; // R8
  assign conv_bus.div_sel = div_reg; // R5
  wire done_evt = conv_bus.done;

  // Address phase and data phase qualifiers
  wire addr_fire = hsel_i && htrans_i[1] && hready_i;
  wire wr_fire = wr_pend_reg && hready_i;
  wire [7:0] wdata = hwdata_i[7:0];

  // Per-register write strobes
  wire wr_pin_en = wr_fire && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_PIN_EN);
  wire wr_ctrl = wr_fire && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_CTRL);
  wire wr_trim = wr_fire && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_TRIM);
  wire wr_irq = wr_fire && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_IRQ_ST);
  wire wr_wake = wr_fire && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_WAKE);
  wire wr_mux = wr_fire && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_PIN_MUX);

  // Channel field locked while busy or done
  wire chan_open = !active_reg && !done_flag_reg; // R10

  // Offset correction on the synchronised sample
  wire [12:0] samp_w = {1'b0, samp_sync_reg};
  wire [12:0] step_w = {9'h000, trim_mag_reg, 1'b0}; // R13
  wire [12:0] sum_w = samp_w + step_w;
  wire [12:0] diff_w = samp_w - step_w;
  wire [11:0] up_w = (sum_w > `ADC_RES_MAX) ? 12'hfff : sum_w[11:0];
  wire [11:0] down_w = diff_w[12] ? 12'h000 : diff_w[11:0];
  wire [11:0] trimmed_w = trim_pos_reg ? up_w : down_w; // R12
  wire [11:0] corrected_w = trim_en_reg ? trimmed_w : samp_sync_reg; // R11

  // Read views of each register
  wire [7:0] ctrl_rd = {ref_sel_reg, div_reg, active_reg, power_reg,
                        chan_reg};
  wire [7:0] trim_rd = {trim_en_reg, trim_pos_reg, trim_mag_reg, 3'h0}; // R14
  wire [7:0] hn_rd = {4'h0, res_reg[11:8]}; // R16
  wire [7:0] irq_rd = {4'h0, done_flag_reg, 3'h0}; // R18
  wire [7:0] wake_rd = {4'h0, wake_en_reg, 3'h0};
  wire [7:0] mux_rd = {6'h00, pwm3_en_reg, comp_en_reg};

  // Read data selection, unmapped offsets read zero
  wire [7:0] rd_mux =
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_PIN_EN) ? pin_en_reg :
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_CTRL) ? ctrl_rd :
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_TRIM) ? trim_rd :
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_RES_UP) ? res_reg[11:4] : // R15
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_RES_HN) ? hn_rd :
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_RES_LO) ? res_reg[7:0] : // R17
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_IRQ_ST) ? irq_rd :
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_WAKE) ? wake_rd :
    reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_PIN_MUX) ? mux_rd :
    `ADC_RST_BYTE;

  // Analog connection per pin, channel 0 yields to the comparator
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_connect
      if (gi == 0)
      begin : g_ch0
        assign connect_next[gi] = pin_en_reg[gi] && !comp_en_reg; // R2
      end
      else
      begin : g_chn
        assign connect_next[gi] = pin_en_reg[gi]; // R1
      end
    end
  endgenerate

  // Shared pin priorities
  wire adc_ch0_fn_t ch0_fn_next = comp_en_reg ? ADC_PIN_COMP :
    (pin_en_reg[0] ? ADC_PIN_ANALOG : ADC_PIN_PORT); // R2
  wire adc_ref_fn_t ref_fn_next = ref_sel_reg ? ADC_REF_VREF :
    (pwm3_en_reg ? ADC_REF_PWM : ADC_REF_PORT); // R4

  // Outputs
  assign hreadyout_o = hreadyout_reg;
  assign hrdata_o = {24'h00_0000, hrdata_reg};
  assign hresp_o = 1'b0;
  assign channel_sel_o = chan_reg; // R9
  assign analog_connect_o = connect_reg;
  assign ref_from_pin_o = ref_sel_reg; // R3
  assign ref_ladder_on_o = power_reg; // R8
  assign ch0_pin_fn_o = ch0_fn_reg;
  assign ref_pin_fn_o = ref_fn_reg;
  assign conversion_wake_o = wake_reg;

  // AHB-Lite phases: writes zero wait, reads one wait state
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      addr_reg <= `ADC_RST_BYTE;
      addr_ok_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= `ADC_RST_BYTE;
    end
    else if (rd_pend_reg)
    begin
      rd_pend_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= rd_mux;
    end
    else if (hready_i)
    begin
      wr_pend_reg <= addr_fire && hwrite_i;
      rd_pend_reg <= addr_fire && !hwrite_i;
      hreadyout_reg <= !(addr_fire && !hwrite_i);
      if (addr_fire)
      begin
        addr_reg <= haddr_i[7:0];
        addr_ok_reg <= (haddr_i[31:8] == 24'h00_0000) && (hsize_i == 3'h2);
      end
    end
  end

  // Pin enable, trim, wake and pin mux registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_en_reg <= `ADC_RST_BYTE;
      trim_en_reg <= 1'b0;
      trim_pos_reg <= 1'b0;
      trim_mag_reg <= 3'h0;
      wake_en_reg <= 1'b0;
      comp_en_reg <= 1'b0;
      pwm3_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_pin_en)
        pin_en_reg <= wdata; // R1
      if (wr_trim)
      begin
        trim_en_reg <= wdata[`ADC_TRIM_EN];
        trim_pos_reg <= wdata[`ADC_TRIM_POS];
        trim_mag_reg <= wdata[`ADC_TRIM_MAG_HI:`ADC_TRIM_MAG_LO];
      end
      if (wr_wake)
        wake_en_reg <= wdata[`ADC_WAKE_BIT];
      if (wr_mux)
      begin
        comp_en_reg <= wdata[`ADC_MUX_COMP];
        pwm3_en_reg <= wdata[`ADC_MUX_PWM3];
      end
    end
  end

  // Converter control register
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_sel_reg <= 1'b0;
      div_reg <= `ADC_DIV_16;
      power_reg <= 1'b0;
      chan_reg <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      ref_sel_reg <= wdata[`ADC_CTL_REFSEL]; // R3
      div_reg <= wdata[`ADC_CTL_DIV_HI:`ADC_CTL_DIV_LO]; // R5
      power_reg <= wdata[`ADC_CTL_POWER]; // R8
      if (chan_open)
        chan_reg <= wdata[`ADC_CTL_CH_HI:`ADC_CTL_CH_LO]; // R10
    end
  end

  // Active bit: software sets, completion alone clears
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      active_reg <= 1'b0;
    else if (done_evt)
      active_reg <= 1'b0; // R15
    else if (wr_ctrl && wdata[`ADC_CTL_ACTIVE])
      active_reg <= 1'b1; // R7
  end

  // Done flag: completion wins over a same-cycle software clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      done_flag_reg <= 1'b0;
    else if (done_evt)
      done_flag_reg <= 1'b1; // R18
    else if (wr_irq && !wdata[`ADC_DONE_BIT])
      done_flag_reg <= 1'b0; // R18
  end

  // Result capture and sample synchroniser
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      samp_meta_reg <= `ADC_RST_RES;
      samp_sync_reg <= `ADC_RST_RES;
      res_reg <= `ADC_RST_RES;
    end
    else
    begin
      samp_meta_reg <= sample_i;
      samp_sync_reg <= samp_meta_reg;
      if (done_evt)
        res_reg <= corrected_w; // R15 R16 R17
    end
  end

  // Registered pin and wake outputs
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      connect_reg <= `ADC_RST_BYTE;
      ch0_fn_reg <= ADC_PIN_PORT;
      ref_fn_reg <= ADC_REF_PORT;
      wake_reg <= 1'b0;
    end
    else
    begin
      connect_reg <= connect_next;
      ch0_fn_reg <= ch0_fn_next;
      ref_fn_reg <= ref_fn_next;
      wake_reg <= done_flag_reg && wake_en_reg;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Channel held while busy or done
  chan_lock_a: assert property ( // R10
    (wr_ctrl && !chan_open) |=> $stable(chan_reg))
    else $error("channel changed while locked");

  // Active bit survives until completion
  active_hold_a: assert property ( // R7
    (active_reg && !done_evt) |=> active_reg)
    else $error("active bit cleared without completion");

  // Completion clears active and raises done flag
  done_set_a: assert property ( // R15
    done_evt |=> (done_flag_reg && !active_reg))
    else $error("completion did not update flags");

  // Result equals corrected sample at completion
  result_load_a: assert property ( // R17
    done_evt |=> (res_reg == $past(corrected_w)))
    else $error("result not loaded at completion");

  // Trim register low bits read zero
  trim_zero_a: assert property ( // R14
    (rd_pend_reg && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_TRIM))
      |=> (hrdata_o[2:0] == 3'h0 && hreadyout_o))
    else $error("trim low bits not zero");

  // High nibble register upper bits read zero
  nibble_zero_a: assert property ( // R16
    (rd_pend_reg && reg_sel(addr_ok_reg, addr_reg, `ADC_OFF_RES_HN))
      |=> (hrdata_o[7:4] == 4'h0 && hrdata_o[3:0] == $past(res_reg[11:8])))
    else $error("high nibble read wrong");

  // Pin enable write reaches the analog switches
  pin_enable_a: assert property ( // R1
    (wr_pin_en && !comp_en_reg) |-> ##2
      (analog_connect_o == $past(hwdata_i[7:0], 2)))
    else $error("analog connect mismatch");

  // No completion while unpowered
  nopower_a: assert property ( // R21
    !power_reg |-> ##2 !$rose(done_flag_reg))
    else $error("done flag set while unpowered");

  // Reference pin priority
  ref_pin_a: assert property ( // R4
    ref_sel_reg |=> (ref_pin_fn_o == ADC_REF_VREF))
    else $error("reference pin priority wrong");

  // Comparator owns channel-0 pin
  ch0_pin_a: assert property ( // R2
    comp_en_reg |=> (ch0_pin_fn_o == ADC_PIN_COMP && !analog_connect_o[0]))
    else $error("channel 0 pin priority wrong");

endmodule // adc_ctrl_top

/* File: adc_front_model.sv */
// Analog pins and converter input: drives the routed channel's value
module adc_front_model (
  // Clock
  input wire logic sys_clk_i,
  // Routing from the block
  input wire logic [2:0] channel_sel_i,
  input wire logic [7:0] analog_connect_i,
  // Converted value of the routed pin
  output logic [11:0] sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] float_reg = 12'h0a5a;

  // Pattern that keeps moving on a pin left unconnected
  always @(posedge sys_clk_i)
    float_reg <= ~float_reg;

  // Pin n carries a level unique to n, only while connected
  assign sample_o = analog_connect_i[channel_sel_i] ?
    {channel_sel_i, 9'h005} : float_reg;
endmodule // adc_front_model

/* File: testbench.sv */
`include "adc_consts.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))

module testbench
  import adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, hsel, hwrite, hready, hresp, ref_pin, ladder, wake;
  logic [1:0] htrans;
  logic [2:0] hsize, ch_sel;
  logic [31:0] haddr, hwdata, hrdata;
  logic [11:0] sample;
  logic [7:0] connect;
  adc_ch0_fn_t ch0_fn;
  adc_ref_fn_t ref_fn;
  int err_total = 0;
  int compares = 0;
  int n;
  int nval [4] = '{16, 4, 64, 8};

  adc_ctrl_top i_adc_ctrl_top (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hready_i(hready), .hwdata_i(hwdata),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp),
    .sample_i(sample), .channel_sel_o(ch_sel), .analog_connect_o(connect),
    .ref_from_pin_o(ref_pin), .ref_ladder_on_o(ladder),
    .ch0_pin_fn_o(ch0_fn), .ref_pin_fn_o(ref_fn),
    .conversion_wake_o(wake));

  adc_front_model i_adc_front_model (.sys_clk_i(sys_clk),
    .channel_sel_i(ch_sel), .analog_connect_i(connect), .sample_o(sample));

  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One AHB-Lite single word transfer, entered just after a clock edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [31:0] q);
    int k;
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (hready !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (hready !== 1'b1 && k < 100);
    q = hrdata;
    if (k >= 100)
    begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus_xfer(1'b0, a, 8'h00, q);
    `CHK(q, {24'h00_0000, e});
  endtask

  // Wait for the completion wake level, counting cycles
  task automatic wait_wake(output int k);
    k = 0;
    while (wake !== 1'b1 && k < 3000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 3000)
    begin
      err_total++;
      end_sim();
    end
  endtask

  // Result registers, flag and active bit after a completion
  task automatic chk_res(input logic [11:0] r, input logic [7:0] ctl);
    chk_rd(`ADC_OFF_RES_UP, r[11:4]);
    chk_rd(`ADC_OFF_RES_HN, {4'h0, r[11:8]});
    chk_rd(`ADC_OFF_RES_LO, r[7:0]);
    chk_rd(`ADC_OFF_IRQ_ST, 8'h08);
    chk_rd(`ADC_OFF_CTRL, ctl);
    wr(`ADC_OFF_IRQ_ST, 8'h08);
    chk_rd(`ADC_OFF_IRQ_ST, 8'h08);
    wr(`ADC_OFF_IRQ_ST, 8'h00);
    chk_rd(`ADC_OFF_IRQ_ST, 8'h00);
  endtask

  function automatic logic [11:0] trim_exp(input logic [11:0] s,
                                           input logic [7:0] t);
    int v;
    v = s;
    if (t[7])
      v = t[6] ? v + 2 * t[5:3] : v - 2 * t[5:3];
    if (v < 0)
      v = 0;
    if (v > 4095)
      v = 4095;
    return 12'(v);
  endfunction

  // Trim cases: trim byte and channel
  logic [7:0] trims [4] = '{8'hf8, 8'h98, 8'hb8, 8'h78};
  logic [2:0] chans [4] = '{3'h7, 3'h2, 3'h0, 3'h1};

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK({ch_sel, connect, ref_pin, ladder, wake, hresp}, 0);
    `CHK({ch0_fn, ref_fn}, {ADC_PIN_PORT, ADC_REF_PORT});
    @(posedge sys_clk);
    for (int a = 0; a <= 8'h24; a += 4)
      chk_rd(8'(a), 8'h00);
    $display("test reset done");

    wr(`ADC_OFF_PIN_EN, 8'ha5);
    chk_rd(`ADC_OFF_PIN_EN, 8'ha5);
    `CHK(connect, 8'ha5);
    wr(`ADC_OFF_TRIM, 8'hff);
    chk_rd(`ADC_OFF_TRIM, 8'hf8);
    wr(8'h24, 8'h5a);
    chk_rd(8'h24, 8'h00);
    $display("test registers done");

    wr(`ADC_OFF_PIN_EN, 8'h01);
    chk_rd(`ADC_OFF_PIN_EN, 8'h01);
    `CHK(ch0_fn, ADC_PIN_ANALOG);
    wr(`ADC_OFF_PIN_MUX, 8'h01);
    chk_rd(`ADC_OFF_PIN_MUX, 8'h01);
    `CHK({ch0_fn, connect[0]}, {ADC_PIN_COMP, 1'b0});
    wr(`ADC_OFF_PIN_EN, 8'h00);
    wr(`ADC_OFF_PIN_MUX, 8'h02);
    wr(`ADC_OFF_CTRL, 8'h80);
    chk_rd(`ADC_OFF_CTRL, 8'h80);
    `CHK({ref_fn, ref_pin, ch0_fn}, {ADC_REF_VREF, 1'b1, ADC_PIN_PORT});
    wr(`ADC_OFF_CTRL, 8'h00);
    chk_rd(`ADC_OFF_CTRL, 8'h00);
    `CHK({ref_fn, ref_pin}, {ADC_REF_PWM, 1'b0});
    wr(`ADC_OFF_PIN_MUX, 8'h00);
    chk_rd(`ADC_OFF_PIN_MUX, 8'h00);
    `CHK(ref_fn, ADC_REF_PORT);
    $display("test pins done");

    wr(`ADC_OFF_PIN_EN, 8'hff);
    wr(`ADC_OFF_WAKE, 8'h08);
    wr(`ADC_OFF_TRIM, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      wr(`ADC_OFF_CTRL, {1'b0, 2'(d), 2'b01, 3'(d + 4)});
      wr(`ADC_OFF_CTRL, {1'b0, 2'(d), 2'b11, 3'(d + 4)});
      wait_wake(n);
      `CHK(n, 14 * nval[d] + 4);
      `CHK(ch_sel, d + 4);
      wr(`ADC_OFF_CTRL, {1'b0, 2'(d), 2'b01, 3'(d + 1)});
      chk_rd(`ADC_OFF_CTRL, {1'b0, 2'(d), 2'b01, 3'(d + 4)});
      chk_res({3'(d + 4), 9'h005}, {1'b0, 2'(d), 2'b01, 3'(d + 4)});
    end
    $display("test dividers done");

    for (int t = 0; t < 4; t++)
    begin
      wr(`ADC_OFF_TRIM, trims[t]);
      wr(`ADC_OFF_CTRL, {3'b001, 2'b01, chans[t]});
      wr(`ADC_OFF_CTRL, {3'b001, 2'b11, chans[t]});
      wait_wake(n);
      chk_res(trim_exp({chans[t], 9'h005}, trims[t]),
              {3'b001, 2'b01, chans[t]});
    end
    $display("test trim done");

    wr(`ADC_OFF_TRIM, 8'h00);
    wr(`ADC_OFF_CTRL, 8'h23);
    wr(`ADC_OFF_CTRL, 8'h33);
    repeat (200) @(posedge sys_clk);
    `CHK({wake, ladder}, 2'b00);
    chk_rd(`ADC_OFF_IRQ_ST, 8'h00);
    chk_rd(`ADC_OFF_RES_UP, 8'h20);
    wr(`ADC_OFF_CTRL, 8'h25);
    chk_rd(`ADC_OFF_CTRL, 8'h33);
    wr(`ADC_OFF_CTRL, 8'h2b);
    chk_rd(`ADC_OFF_CTRL, 8'h3b);
    `CHK({ladder, ch_sel}, 4'hb);
    wait_wake(n);
    chk_res(12'h605, 8'h2b);
    $display("test power done");
    end_sim();
  end
endmodule // testbench
